// >>> verilog/etw_target.v
`timescale 1ns/100ps
`default_nettype none
`include "etw_regs.vh"

module etw_target #(
    parameter HAS_CS_PINS = 1,                              // 0 for variants lacking the straps
    parameter CNT_W       = 20,                             // Write timer width
    parameter WR_CYCLES   = `ETW_T_WR_NS / `ETW_CLK_NS      // Write cycle length in clocks
) (
    input  wire       CORE_CLK_I,          // Core clock, 125 MHz
    input  wire       RESETN_I,            // Asynchronous reset, active low
    input  wire       SCL_I,               // Serial clock pin level
    input  wire       SDA_I,               // Serial data pin level
    output reg        SDA_O,               // Serial data output value, always low
    output reg        SDA_OE_O,            // High while pulling data low
    input  wire       CHIP_SELECT_IN_2_I,  // Strapped chip-select 2
    input  wire       CHIP_SELECT_IN_1_I,  // Strapped chip-select 1
    input  wire       CHIP_SELECT_IN_0_I,  // Strapped chip-select 0
    input  wire       WP_I,                // Write protect, high blocks writes
    input  wire [7:0] TX_DATA_I,           // Next byte to send in a read
    output reg        TX_TAKEN_O,          // Pulse: TX_DATA_I was loaded
    output reg  [7:0] RX_DATA_O,           // Last data word received in a write
    output reg        RX_VALID_O,          // Pulse: RX_DATA_O holds a new word
    output reg        READ_MODE_O,         // Level: addressed for a read
    output reg        WRITE_MODE_O,        // Level: addressed for a write
    output reg        WRITE_COMMIT_O,      // Pulse: internal write cycle starts
    output reg        WRITE_BUSY_O,        // Level: internal write cycle running
    output reg        STANDBY_O            // Level: device in standby
);

    // One-hot states
    // A corrupted code lands in the default branch and idles the engine
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_ADDR  = 7'h02;
    localparam [6:0] ST_AACK  = 7'h04;
    localparam [6:0] ST_WDATA = 7'h08;
    localparam [6:0] ST_WACK  = 7'h10;
    localparam [6:0] ST_RDATA = 7'h20;
    localparam [6:0] ST_RACK  = 7'h40;

    // Last timer value; the 32-bit difference is cut to the timer width on purpose
    localparam [31:0]      WR_LAST_I = WR_CYCLES - 1;
    localparam [CNT_W-1:0] WR_LAST   = WR_LAST_I[CNT_W-1:0];

    // Two-stage synchronisers; stage one feeds stage two only
    reg [`ETW_SY_WIDTH-1:0] sync_a;
    reg [`ETW_SY_WIDTH-1:0] sync_b;
    reg                     scl_q;
    reg                     sda_q;
    reg [6:0]               state;
    reg [3:0]               bit_cnt;
    reg [7:0]               shreg;
    // A stop commits only when at least one data word arrived
    reg                     got_data;
    reg                     host_ack;
    reg [CNT_W-1:0]         wr_cnt;

    // Settled pin levels; nothing below reads the first stage
    wire       scl_s = sync_b[`ETW_SY_SCL];
    wire       sda_s = sync_b[`ETW_SY_SDA];
    wire       wp_s  = sync_b[`ETW_SY_WP];
    wire [2:0] cs_s  = sync_b[`ETW_SY_CS_MSB:0];

    // Edges and bus conditions seen on the synchronised pins. Every event lags
    // its pin by three core clocks, so each bus clock phase must last longer
    // than that; a slower core clock would miss data set up late in the low time
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    // Address word check against type and straps
    function addr_match;
        input [7:0] word;
        input [2:0] straps;
        begin
            addr_match = (word[`ETW_TYPE_MSB:`ETW_TYPE_LSB] == `ETW_TYPE_ID) &&
                         (word[`ETW_CS_MSB:`ETW_CS_LSB] == straps);
        end
    endfunction

    // Shift one sampled bit in at the bottom; the wire carries the MSB first
    function [7:0] shift_in;
        input [7:0] word;
        input       bit_in;
        begin
            shift_in = {word[6:0], bit_in};
        end
    endfunction

    // Open-drain output: a zero is a pull, a one is a release
    function pull_for;
        input bit_out;
        begin
            pull_for = ~bit_out;
        end
    endfunction

    // Variants without strap pins compare against zero
    wire [2:0] strap_ref = (HAS_CS_PINS != 0) ? cs_s : 3'h0;

    // Pin sampling; the extra stage only remembers the last settled level
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            // Idle bus level, so the release of reset shows no false start
            sync_a <= {`ETW_SY_WIDTH{1'b1}};
            sync_b <= {`ETW_SY_WIDTH{1'b1}};
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            sync_a <= {SCL_I, SDA_I, WP_I, CHIP_SELECT_IN_2_I,
                       CHIP_SELECT_IN_1_I, CHIP_SELECT_IN_0_I};
            sync_b <= sync_a;
            scl_q  <= scl_s;
            sda_q  <= sda_s;
        end
    end

    // Self-timed write; the timer runs from the stop, never from a clock edge
    // on the bus, so a host that stops clocking cannot stretch it
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            WRITE_BUSY_O   <= 1'b0;
            WRITE_COMMIT_O <= 1'b0;
            wr_cnt         <= {CNT_W{1'b0}};
        end else begin
            // Commit is a one-clock pulse; a stop seen while busy starts nothing,
            // because the running cycle owns the array until it ends
            WRITE_COMMIT_O <= 1'b0;
            if (WRITE_BUSY_O) begin
                if (wr_cnt == WR_LAST) begin
                    WRITE_BUSY_O <= 1'b0;
                    wr_cnt       <= {CNT_W{1'b0}};
                end else begin
                    wr_cnt <= wr_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end else if (stop_c && WRITE_MODE_O && got_data && !wp_s) begin
                WRITE_BUSY_O   <= 1'b1;
                WRITE_COMMIT_O <= 1'b1;
            end
        end
    end

    // Protocol engine; the data pin is only ever pulled low or released
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state        <= ST_IDLE;
            bit_cnt      <= 4'h0;
            shreg        <= 8'h00;
            got_data     <= 1'b0;
            host_ack     <= 1'b0;
            SDA_O        <= 1'b0;
            SDA_OE_O     <= 1'b0;
            TX_TAKEN_O   <= 1'b0;
            RX_DATA_O    <= 8'h00;
            RX_VALID_O   <= 1'b0;
            READ_MODE_O  <= 1'b0;
            WRITE_MODE_O <= 1'b0;
            STANDBY_O    <= 1'b1;
        end else begin
            // Pulses last one clock; standby follows the state one clock later
            TX_TAKEN_O <= 1'b0;
            RX_VALID_O <= 1'b0;
            STANDBY_O  <= (state == ST_IDLE) && !WRITE_BUSY_O;
            if (WRITE_BUSY_O) begin
                // Deaf and silent until the array is programmed
                state        <= ST_IDLE;
                SDA_OE_O     <= 1'b0;
                READ_MODE_O  <= 1'b0;
                WRITE_MODE_O <= 1'b0;
                got_data     <= 1'b0;
            end else if (start_c) begin
                // A start anywhere aborts the word in flight
                state        <= ST_ADDR;
                bit_cnt      <= 4'h0;
                SDA_OE_O     <= 1'b0;
                READ_MODE_O  <= 1'b0;
                WRITE_MODE_O <= 1'b0;
                got_data     <= 1'b0;
            end else if (stop_c) begin
                // Stop ends any sequence; the write timer takes over if needed
                state        <= ST_IDLE;
                SDA_OE_O     <= 1'b0;
                READ_MODE_O  <= 1'b0;
                WRITE_MODE_O <= 1'b0;
            end else begin
                case (state)
                    // Released and deaf until the next start
                    ST_IDLE: begin
                        SDA_OE_O <= 1'b0;
                    end
                    // Device address word; judged once the eighth bit is clocked in
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shreg   <= shift_in(shreg, sda_s);
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `ETW_WORD_BITS) begin
                            if (addr_match(shreg, strap_ref)) begin
                                SDA_OE_O <= 1'b1;
                                state    <= ST_AACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    // Acknowledge clock; its fall hands the line to the host or our data
                    ST_AACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (shreg[`ETW_RW_BIT]) begin
                                READ_MODE_O <= 1'b1;
                                shreg       <= TX_DATA_I;
                                TX_TAKEN_O  <= 1'b1;
                                SDA_OE_O    <= pull_for(TX_DATA_I[7]);
                                state       <= ST_RDATA;
                            end else begin
                                WRITE_MODE_O <= 1'b1;
                                SDA_OE_O     <= 1'b0;
                                state        <= ST_WDATA;
                            end
                        end
                    end
                    // Write data; acknowledged even when protected, only the commit is blocked
                    ST_WDATA: begin
                        if (scl_rise) begin
                            shreg   <= shift_in(shreg, sda_s);
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `ETW_WORD_BITS) begin
                            RX_DATA_O  <= shreg;
                            RX_VALID_O <= 1'b1;
                            got_data   <= 1'b1;
                            SDA_OE_O   <= 1'b1;
                            state      <= ST_WACK;
                        end
                    end
                    // Our acknowledge stands until the ninth falling edge
                    ST_WACK: begin
                        if (scl_fall) begin
                            SDA_OE_O <= 1'b0;
                            bit_cnt  <= 4'h0;
                            state    <= ST_WDATA;
                        end
                    end
                    // Read data; each falling edge but the eighth puts out the next bit, MSB first
                    ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == `ETW_WORD_BITS) begin
                                SDA_OE_O <= 1'b0;            // Host acknowledges now
                                state    <= ST_RACK;
                            end else begin
                                shreg    <= shift_in(shreg, 1'b0);
                                SDA_OE_O <= pull_for(shreg[6]);
                            end
                        end
                    end
                    // Host acknowledge clock; a low level asks for another byte
                    ST_RACK: begin
                        if (scl_rise) begin
                            host_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (host_ack) begin
                                shreg      <= TX_DATA_I;
                                TX_TAKEN_O <= 1'b1;
                                SDA_OE_O   <= pull_for(TX_DATA_I[7]);
                                state      <= ST_RDATA;
                            end else begin
                                // No acknowledge: wait released for the stop
                                state <= ST_IDLE;
                            end
                        end
                    end
                    // Unreachable codes recover to idle with the line released
                    default: begin
                        state    <= ST_IDLE;
                        SDA_OE_O <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// >>> include/etw_regs.vh
`ifndef ETW_REGS_VH
`define ETW_REGS_VH

// Device address word layout
`define ETW_TYPE_ID      4'ha
`define ETW_TYPE_MSB     7
`define ETW_TYPE_LSB     4
`define ETW_CS_MSB       3
`define ETW_CS_LSB       1
`define ETW_RW_BIT       0

// Bits in one word, and the acknowledge follows them
`define ETW_WORD_BITS    4'h8

// Self-timed write cycle time and the core clock period
`define ETW_T_WR_NS      5000000
`define ETW_CLK_NS       8

// Synchroniser vector positions
`define ETW_SY_SCL       5
`define ETW_SY_SDA       4
`define ETW_SY_WP        3
`define ETW_SY_CS_MSB    2
`define ETW_SY_WIDTH     6

`endif

// >>> testbench/etw_target_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the bus target, one clock domain
module etw_target_monitor #(
    parameter WR_CYCLES = 625000  // Write cycle length
) (
    input wire CORE_CLK_I,      // Core clock
    input wire RESETN_I,        // Reset, low
    input wire SCL_I,           // Bus clock
    input wire WP_I,            // Write protect
    input wire SDA_O,           // Data value
    input wire SDA_OE_O,        // Data pull
    input wire RX_VALID_O,      // Word pulse
    input wire TX_TAKEN_O,      // Load pulse
    input wire READ_MODE_O,     // Read level
    input wire WRITE_MODE_O,    // Write level
    input wire WRITE_COMMIT_O,  // Commit pulse
    input wire WRITE_BUSY_O,    // Busy level
    input wire STANDBY_O        // Standby level
);
    int cnt;  // Clocks since the last commit
    // Restarted by each commit; never wraps within a bench run
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I)
            cnt <= 0;
        else
            cnt <= WRITE_COMMIT_O ? 0 : cnt + 1;
    end
    default clocking @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESETN_I);
    property p_pull_only;
        SDA_O == 1'b0;
    endproperty
    a_pull_only: assert property (p_pull_only) else $error("data value not low");
    // Sync latency keeps every data pull change inside the clock low time
    property p_oe_clk_low;
        $changed(SDA_OE_O) |-> !SCL_I;
    endproperty
    a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved, clock high");
    property p_busy_quiet;
        WRITE_BUSY_O |-> !SDA_OE_O;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
    property p_wp_block;
        WRITE_COMMIT_O |-> !WP_I ##1 WRITE_BUSY_O;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("bad commit");
    property p_busy_len;
        $fell(WRITE_BUSY_O) |-> cnt == WR_CYCLES - 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length");
    property p_busy_awake;
        WRITE_BUSY_O && $past(WRITE_BUSY_O) |-> !STANDBY_O;
    endproperty
    a_busy_awake: assert property (p_busy_awake) else $error("standby while busy");
    property p_one_mode;
        !(READ_MODE_O && WRITE_MODE_O);
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("read and write at once");
    property p_rx_write;
        RX_VALID_O |-> WRITE_MODE_O;
    endproperty
    a_rx_write: assert property (p_rx_write) else $error("word outside write");
    property p_tx_read;
        TX_TAKEN_O |-> READ_MODE_O;
    endproperty
    a_tx_read: assert property (p_tx_read) else $error("byte load outside read");
endmodule
`default_nettype wire

// >>> testbench/etw_host.sv
`timescale 1ns/100ps
`default_nettype none
// Bus host: paces the clock from the core clock, pulls data through its enable
module etw_host (
    input  wire logic clk_i,    // Core clock
    input  wire logic sda_i,    // Resolved data wire
    output var logic  scl_o,    // Bus clock, still between frames
    output var logic  sda_oe_o  // High while pulling low
);
    // Idle bus at time zero
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One 80 ns bit; data set mid low time, sampled at the end of high time
    task automatic one_bit(input logic b, output logic r);
        w(2);
        sda_oe_o = !b;
        w(3);
        scl_o = 1'b1;
        w(5);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    // Releases first, so it also serves as a repeated start
    task automatic start;
        w(2);
        sda_oe_o = 1'b0;
        w(3);
        scl_o = 1'b1;
        w(5);
        sda_oe_o = 1'b1;
        w(5);
        scl_o = 1'b0;
    endtask
    task automatic stop;
        w(2);
        sda_oe_o = 1'b1;
        w(3);
        scl_o = 1'b1;
        w(5);
        sda_oe_o = 1'b0;
        w(5);
    endtask
    // Word MSB first, then ninth bit: a9 low acknowledges a read word
    task automatic word(input logic [7:0] d, input logic a9, output logic [7:0] q,
                        output logic r9);
        int i;
        for (i = 7; i >= 0; i--)
            one_bit(d[i], q[i]);
        one_bit(a9, r9);
    endtask
endmodule
`default_nettype wire

// >>> testbench/etw_target_tb.sv
`timescale 1ns/100ps
`default_nettype none
module etw_target_tb;
    localparam int WR_CYCLES = 300;  // Short write cycle, still longer than a poll
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wp = 1'b0;
    logic [2:0]  cs = 3'h0;
    logic [7:0]  txd = 8'h00;
    logic [7:0]  d;
    logic [7:0]  q;
    logic        r;
    logic [31:0] seed = 32'h8a16818d;
    int          failures = 0;
    int          checks = 0;
    int          i;
    wire         scl;
    wire         hoe;
    wire         oe;
    wire         busy;
    wire         stby;
    wire [7:0]   rxd;
    wire         sda = !(hoe || oe);  // Pull-up wins unless a party pulls
    always #4 clk = !clk;
    etw_target #(.WR_CYCLES(WR_CYCLES)) etw_target_i (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE_O(oe), .CHIP_SELECT_IN_2_I(cs[2]), .CHIP_SELECT_IN_1_I(cs[1]),
        .CHIP_SELECT_IN_0_I(cs[0]), .WP_I(wp), .TX_DATA_I(txd), .TX_TAKEN_O(),
        .RX_DATA_O(rxd), .RX_VALID_O(), .READ_MODE_O(), .WRITE_MODE_O(),
        .WRITE_COMMIT_O(), .WRITE_BUSY_O(busy), .STANDBY_O(stby)
    );
    etw_host etw_host_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(hoe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chkb(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t bit %b want %b", $time, g, e);
        end
    endtask
    task automatic chkw(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t word %h want %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic addr(input logic [7:0] a);
        etw_host_i.start;
        etw_host_i.word(a, 1'b1, q, r);
    endtask
    // Hang guard
    initial begin
        #600000;
        failures++;
        wrap_up;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        etw_host_i.w(4);
        chkb(stby, 1'b1);
        seed = xs(seed);
        cs = seed[2:0];
        // Protected write, then open write; both words acknowledged
        for (i = 0; i < 2; i++) begin
            wp = (i == 0);
            seed = xs(seed);
            d = seed[15:8];
            addr({4'ha, cs, 1'b0});
            chkb(r, 1'b0);
            etw_host_i.word(d, 1'b1, q, r);
            chkb(r, 1'b0);
            chkw(rxd, d);
            etw_host_i.stop;
            chkb(busy, i[0]);
        end
        // Polling inside the write cycle gets no acknowledge
        addr({4'ha, cs, 1'b0});
        chkb(r, 1'b1);
        etw_host_i.stop;
        for (i = 0; i < 400 && busy !== 1'b0; i++)
            @(negedge clk);
        if (i == 400) begin
            failures++;
            wrap_up;
        end
        etw_host_i.w(2);
        chkb(stby, 1'b1);
        // Wrong strap, then wrong type prefix; the next word is ignored too
        for (i = 0; i < 2; i++) begin
            addr(i ? {4'h5, cs, 1'b1} : {4'ha, cs ^ 3'h5, 1'b0});
            chkb(r, 1'b1);
            etw_host_i.word(8'h00, 1'b1, q, r);
            chkb(r, 1'b1);
            chkb(stby, 1'b1);
            etw_host_i.stop;
        end
        // Read two bytes: host acknowledges the first and declines the second
        seed = xs(seed);
        txd = seed[23:16];
        d = seed[31:24];
        addr({4'ha, cs, 1'b1});
        chkb(r, 1'b0);
        etw_host_i.w(4);
        txd = d;  // First byte is loaded by now; offer the next
        etw_host_i.word(8'hff, 1'b0, q, r);
        chkw(q, seed[23:16]);
        etw_host_i.w(4);
        etw_host_i.word(8'hff, 1'b1, q, r);
        chkw(q, d);
        etw_host_i.stop;
        etw_host_i.w(3);
        chkb(stby, 1'b1);
        // Start in mid-word restarts address reception
        etw_host_i.start;
        for (i = 0; i < 4; i++)
            etw_host_i.one_bit(seed[i], r);
        addr({4'ha, cs, 1'b0});
        chkb(r, 1'b0);
        // Recovery: start, nine clocks, start, stop; address-only write commits nothing
        etw_host_i.start;
        for (i = 0; i < 9; i++)
            etw_host_i.one_bit(1'b1, r);
        etw_host_i.start;
        etw_host_i.stop;
        addr({4'ha, cs, 1'b0});
        chkb(r, 1'b0);
        etw_host_i.stop;
        etw_host_i.w(3);
        chkb(busy, 1'b0);
        wrap_up;
    end
endmodule
bind etw_target etw_target_monitor #(.WR_CYCLES(WR_CYCLES)) etw_target_monitor_i (
    .CORE_CLK_I, .RESETN_I, .SCL_I, .WP_I, .SDA_O, .SDA_OE_O, .RX_VALID_O, .TX_TAKEN_O,
    .READ_MODE_O, .WRITE_MODE_O, .WRITE_COMMIT_O, .WRITE_BUSY_O, .STANDBY_O
);
`default_nettype wire
